// *** tdu_pkg.sv ***
// shared constants and types for the trellis despread unit
// Function
// - logmax add: path-score double plus quad halves, then log-max of the sums
// - logmax subtract: path-score double minus quad halves, then log-max of differences
// - register logmax: log-max between two path-score words into general register
// - plain max add: sums of path-score doubles and quad halves, keep larger
// - plain max subtract: differences of path-score doubles and quad halves, keep larger
// - max ops pair only with shifter, multiplier or register load, never alu/comms op
// - max, logmax and accumulating despread support optional result saturation
// - live overflow flag recomputed every cycle from current operation
// - sticky overflow set on any overflow, cleared only by status write
// - moves carry 32, 64 or 128 bits; index aligned to size
// - path-score and history transfers take effect in second execute stage
// - quad history transfers reserved and refused; only two history words
// - history load paired with history shift: the load wins
// - register moves pair with shifter or multiplier only, not alu/comms op
// - interleave double load: low bit k to 2k, high bit k to 2k+1
// - despread samples: eight complex byte pairs, real low, imaginary high
// - history gives eight code pairs, real bit low; clear +1, set -1
// - history shifts right sixteen bits after each despread
// - accumulating despread sums samples 0..7 and adds prior path-score word
// - products are +/-1 multiplies, sums sign extended into result shorts
// - single dual despread sums samples 0..3, old path score to general
// - double dual despread: samples 0..3 first word, 4..7 second word
// - despread pairs with multiplier or register load only
// - logmax is maximum plus table correction for ln(1+exp(-|a-b|))
package tdu_pkg;
    localparam int          ADDR_W   = 8;
    localparam int          DATA_W   = 32;
    localparam int          PSF_DEPTH = 16;
    // ========================================
    // register map (byte addresses)
    localparam logic [7:0]  A_CMD    = 8'h00;
    localparam logic [7:0]  A_STAT   = 8'h04;
    localparam logic [7:0]  A_OPQ    = 8'h10;
    localparam logic [7:0]  A_GRES   = 8'h20;
    localparam logic [7:0]  A_HIST   = 8'h30;
    localparam logic [7:0]  A_HLD    = 8'h38;
    localparam logic [7:0]  A_PSF    = 8'h40;
    localparam logic [7:0]  A_END    = 8'h80;
    localparam int          ST_NOW   = 0;
    localparam int          ST_STK   = 1;
    localparam int          ST_PAIR  = 2;
    localparam int          ST_ALIGN = 3;
    // ========================================
    // datapath constants
    localparam int          HIST_SHIFT = 16;
    localparam int          HALF_SAMP  = 4;
    localparam logic [15:0] SHORT_MAX  = 16'h7fff;
    localparam logic [15:0] SHORT_MIN  = 16'h8000;
    localparam int          LM_SHIFT   = 2;
    localparam logic [2:0]  LM_TOP     = 3'h7;
    // correction in score units, indexed by |a-b| >> LM_SHIFT
    localparam logic [15:0] LM_TAB [0:7] = '{16'h0003, 16'h0002, 16'h0002, 16'h0001,
                                             16'h0001, 16'h0001, 16'h0001, 16'h0000};
    // ========================================
    // command encoding
    typedef enum logic [3:0] {
        OP_NOP, OP_LMAX_ADD, OP_LMAX_SUB, OP_LMAX_REG, OP_MAX_ADD, OP_MAX_SUB,
        OP_MV_PS_G, OP_MV_G_PS, OP_MV_H_G, OP_MV_G_H, OP_DSP_ACC, OP_DSP_SGL, OP_DSP_DBL
    } tdu_op_t;
    typedef enum logic [2:0] {
        PR_NONE, PR_SHIFT, PR_MULT, PR_COMM_LOAD, PR_ALU, PR_COMM_OP
    } tdu_pair_t;
    typedef enum logic [1:0] {
        SZ_WORD, SZ_DBL, SZ_QUAD, SZ_RSV
    } tdu_size_t;
    typedef struct packed {
        logic [7:0] rsv;
        logic       ilv;
        tdu_pair_t  pair;
        logic       hload;
        tdu_size_t  size;
        logic [3:0] n_idx;
        logic [3:0] m_idx;
        logic [3:0] s_idx;
        logic       sat;
        tdu_op_t    op;
    } tdu_cmd_t;
endpackage : tdu_pkg

// *** tdu_unit.sv ***
// trellis max / despread datapath with avalon-mm register slave
`timescale 1ns/1ps
module tdu_unit (
    input  wire logic                      core_clk,           // 100 mhz clock
    input  wire logic                      nrst,               // sync reset, active low
    input  wire logic [tdu_pkg::ADDR_W-1:0] avs_address,       // byte address
    input  wire logic                      avs_read,           // read request
    input  wire logic                      avs_write,          // write request
    input  wire logic [tdu_pkg::DATA_W-1:0] avs_writedata,     // write data
    input  wire logic [3:0]                avs_byteenable,     // write byte lanes
    output logic      [tdu_pkg::DATA_W-1:0] avs_readdata,      // read data
    output logic                           avs_waitrequest,    // stall
    output logic                           overflow_now_flag,  // live overflow
    output logic                           overflow_sticky_flag // sticky overflow
);
    // ========================================
    // storage
    logic [31:0]       psf_q  [0:tdu_pkg::PSF_DEPTH-1];
    logic [31:0]       hist_q [0:1];
    logic [31:0]       hld_q  [0:1];
    logic [31:0]       opq_q  [0:3];
    logic [31:0]       gres_q [0:3];
    tdu_pkg::tdu_cmd_t cmd_q;
    tdu_pkg::tdu_cmd_t ex_q;
    logic              ex_v_q;
    logic              now_q;
    logic              stk_q;
    logic              perr_q;
    logic              aerr_q;
    logic              ack_q;
    logic [31:0]       rdata_q;

    // ========================================
    // helpers
    function automatic logic [16:0] add_s(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub, input logic sat);
        logic [16:0] s;
        logic        ov;
        logic [15:0] r;
        s  = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
        ov = s[16] ^ s[15];
        r  = s[15:0];
        if (ov && sat)
            r = s[16] ? tdu_pkg::SHORT_MIN : tdu_pkg::SHORT_MAX;
        return {ov, r};
    endfunction : add_s

    function automatic logic [15:0] max_s(input logic [15:0] a, input logic [15:0] b);
        return ($signed(a) >= $signed(b)) ? a : b;
    endfunction : max_s

    function automatic logic [16:0] lmax_s(input logic [15:0] a, input logic [15:0] b,
                                           input logic sat);
        logic [16:0] d;
        logic [16:0] ad;
        logic [16:0] ix;
        logic [2:0]  k;
        d  = {a[15], a} - {b[15], b};
        ad = d[16] ? (17'h0 - d) : d;
        ix = ad >> tdu_pkg::LM_SHIFT;
        k  = (ix > 17'(tdu_pkg::LM_TOP)) ? tdu_pkg::LM_TOP : ix[2:0];
        return add_s(max_s(a, b), tdu_pkg::LM_TAB[k], 1'b0, sat);
    endfunction : lmax_s

    // interleave two words into the history pair
    function automatic logic [63:0] ilv(input logic [31:0] lo, input logic [31:0] hi);
        logic [63:0] v;
        v = '0;
        for (int k = 0; k < 32; k++)
        begin
            v[2*k]   = lo[k];
            v[2*k+1] = hi[k];
        end
        return v;
    endfunction : ilv

    // complex sum over four samples from lo, code bits +/-1
    function automatic logic [31:0] desp(input logic [127:0] d, input logic [15:0] b, input int lo);
        logic [15:0] sr;
        logic [15:0] si;
        logic [15:0] di;
        logic [15:0] dq;
        sr = '0;
        si = '0;
        for (int n = lo; n < lo + tdu_pkg::HALF_SAMP; n++)
        begin
            di = {{8{d[16*n+7]}}, d[16*n +: 8]};
            dq = {{8{d[16*n+15]}}, d[16*n+8 +: 8]};
            sr = sr + (b[2*n] ? 16'h0 - di : di) - (b[2*n+1] ? 16'h0 - dq : dq);
            si = si + (b[2*n] ? 16'h0 - dq : dq) + (b[2*n+1] ? 16'h0 - di : di);
        end
        return {si, sr};
    endfunction : desp

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = n[8*i +: 8];
        return r;
    endfunction : be_merge

    // ========================================
    // bus decode
    logic        req;
    logic        acc;
    logic [3:0]  widx;
    logic [31:0] rd_mux;
    assign req  = avs_read | avs_write;
    // hold off the bus while a command sits in the execute stage
    assign acc  = req & ~ack_q & ~ex_v_q;
    assign widx = avs_address[5:2];
    assign avs_waitrequest      = req & ~ack_q;
    assign avs_readdata         = rdata_q;
    assign overflow_now_flag    = now_q;
    assign overflow_sticky_flag = stk_q;

    always_comb
    begin
        rd_mux = '0;
        if (avs_address == tdu_pkg::A_CMD)
            rd_mux = cmd_q;
        else if (avs_address == tdu_pkg::A_STAT)
        begin
            rd_mux[tdu_pkg::ST_NOW]   = now_q;
            rd_mux[tdu_pkg::ST_STK]   = stk_q;
            rd_mux[tdu_pkg::ST_PAIR]  = perr_q;
            rd_mux[tdu_pkg::ST_ALIGN] = aerr_q;
        end
        else if (avs_address >= tdu_pkg::A_OPQ && avs_address < tdu_pkg::A_GRES)
            rd_mux = opq_q[widx[1:0]];
        else if (avs_address >= tdu_pkg::A_GRES && avs_address < tdu_pkg::A_HIST)
            rd_mux = gres_q[widx[1:0]];
        else if (avs_address >= tdu_pkg::A_HIST && avs_address < tdu_pkg::A_HLD)
            rd_mux = hist_q[widx[0]];
        else if (avs_address >= tdu_pkg::A_HLD && avs_address < tdu_pkg::A_PSF)
            rd_mux = hld_q[widx[0]];
        else if (avs_address >= tdu_pkg::A_PSF && avs_address < tdu_pkg::A_END)
            rd_mux = psf_q[widx];
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= acc;
            if (acc && avs_read)
                rdata_q <= rd_mux;
        end
    end

    logic wr_ack;
    assign wr_ack = avs_write & ack_q;

    // ========================================
    // issue: command write loads the execute stage
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cmd_q  <= '0;
            ex_q   <= '0;
            ex_v_q <= 1'b0;
        end
        else
        begin
            ex_v_q <= wr_ack && avs_address == tdu_pkg::A_CMD;
            if (wr_ack && avs_address == tdu_pkg::A_CMD)
            begin
                cmd_q <= be_merge(cmd_q, avs_writedata, avs_byteenable);
                ex_q  <= be_merge(cmd_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // ========================================
    // second execute stage
    tdu_pkg::tdu_cmd_t c;
    logic        is_max;
    logic        is_dsp;
    logic        is_mv;
    logic        pair_bad;
    logic        align_bad;
    logic        go;
    logic [3:0]  s1;
    logic [3:0]  m1;
    logic [3:0]  n1;
    logic [2:0]  nw;
    logic [63:0] trm;
    logic [63:0] trn;
    logic [63:0] qhi;
    logic [63:0] qlo;
    logic [63:0] res64;
    logic [127:0] q128;
    logic [15:0] hbits;
    logic [16:0] t0;
    logic [16:0] t1;
    logic [31:0] acc32;
    logic [31:0] res_w [0:3];
    logic [3:0]  psf_we;
    logic [31:0] g_w   [0:3];
    logic [3:0]  g_we;
    logic [63:0] h_val;
    logic [1:0]  h_we;
    logic        h_shift;
    logic        ovf;

    assign c      = ex_q;
    assign s1     = 4'(c.s_idx + 4'h1);
    assign m1     = 4'(c.m_idx + 4'h1);
    assign n1     = 4'(c.n_idx + 4'h1);
    assign trm    = {psf_q[m1], psf_q[c.m_idx]};
    assign trn    = {psf_q[n1], psf_q[c.n_idx]};
    assign qhi    = {opq_q[3], opq_q[2]};
    assign qlo    = {opq_q[1], opq_q[0]};
    assign q128   = {opq_q[3], opq_q[2], opq_q[1], opq_q[0]};
    assign hbits  = hist_q[0][15:0];
    assign is_max = c.op inside {tdu_pkg::OP_LMAX_ADD, tdu_pkg::OP_LMAX_SUB, tdu_pkg::OP_LMAX_REG,
                                 tdu_pkg::OP_MAX_ADD, tdu_pkg::OP_MAX_SUB};
    assign is_dsp = c.op inside {tdu_pkg::OP_DSP_ACC, tdu_pkg::OP_DSP_SGL, tdu_pkg::OP_DSP_DBL};
    assign is_mv  = c.op inside {tdu_pkg::OP_MV_PS_G, tdu_pkg::OP_MV_G_PS,
                                 tdu_pkg::OP_MV_H_G, tdu_pkg::OP_MV_G_H};
    assign nw     = (c.size == tdu_pkg::SZ_QUAD) ? 3'h4 : (c.size == tdu_pkg::SZ_DBL) ? 3'h2 : 3'h1;

    assign pair_bad = c.pair inside {tdu_pkg::PR_ALU, tdu_pkg::PR_COMM_OP}
                      || (is_mv && c.pair == tdu_pkg::PR_COMM_LOAD)
                      || (is_dsp && c.pair == tdu_pkg::PR_SHIFT);

    always_comb
    begin
        align_bad = 1'b0;
        if (is_mv)
        begin
            align_bad = (c.size == tdu_pkg::SZ_RSV)
                        || (c.size == tdu_pkg::SZ_DBL && c.s_idx[0])
                        || (c.size == tdu_pkg::SZ_QUAD && c.s_idx[1:0] != 2'h0)
                        || (c.ilv && !(c.op == tdu_pkg::OP_MV_G_H && c.size == tdu_pkg::SZ_DBL));
            if (c.op inside {tdu_pkg::OP_MV_H_G, tdu_pkg::OP_MV_G_H})
                align_bad = align_bad || c.size == tdu_pkg::SZ_QUAD || c.s_idx[3:1] != 3'h0;
        end
        else if (is_max && c.op != tdu_pkg::OP_LMAX_REG)
            align_bad = c.s_idx[0] | c.m_idx[0] | c.n_idx[0];
        else if (c.op == tdu_pkg::OP_DSP_DBL)
            align_bad = c.s_idx[0];
    end

    assign go = ex_v_q & ~pair_bad & ~align_bad;

    always_comb
    begin
        res64   = '0;
        t0      = '0;
        t1      = '0;
        acc32   = '0;
        psf_we  = '0;
        g_we    = '0;
        h_we    = '0;
        h_val   = '0;
        h_shift = 1'b0;
        ovf     = 1'b0;
        for (int w = 0; w < 4; w++)
        begin
            res_w[w] = '0;
            g_w[w]   = '0;
        end
        case (c.op)
            tdu_pkg::OP_LMAX_ADD, tdu_pkg::OP_LMAX_SUB, tdu_pkg::OP_MAX_ADD, tdu_pkg::OP_MAX_SUB:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    // high half to first double, low to second
                    t0 = add_s(trm[16*k +: 16], qhi[16*k +: 16], c.op inside {tdu_pkg::OP_LMAX_SUB,
                               tdu_pkg::OP_MAX_SUB}, c.sat);
                    t1 = add_s(trn[16*k +: 16], qlo[16*k +: 16], c.op inside {tdu_pkg::OP_LMAX_SUB,
                               tdu_pkg::OP_MAX_SUB}, c.sat);
                    ovf = ovf | t0[16] | t1[16];
                    if (c.op inside {tdu_pkg::OP_MAX_ADD, tdu_pkg::OP_MAX_SUB})
                        res64[16*k +: 16] = max_s(t0[15:0], t1[15:0]);
                    else
                    begin
                        t0 = lmax_s(t0[15:0], t1[15:0], c.sat);
                        ovf = ovf | t0[16];
                        res64[16*k +: 16] = t0[15:0];
                    end
                end
                res_w[0] = res64[31:0];
                res_w[1] = res64[63:32];
                psf_we   = 4'h3;
            end
            tdu_pkg::OP_LMAX_REG:
            begin
                // log-max of two path-score words into general result
                for (int k = 0; k < 2; k++)
                begin
                    t0 = lmax_s(psf_q[c.m_idx][16*k +: 16], psf_q[c.n_idx][16*k +: 16], c.sat);
                    ovf = ovf | t0[16];
                    g_w[0][16*k +: 16] = t0[15:0];
                end
                g_we = 4'h1;
            end
            tdu_pkg::OP_MV_PS_G, tdu_pkg::OP_MV_G_PS, tdu_pkg::OP_MV_H_G:
            begin
                for (int w = 0; w < 4; w++)
                begin
                    if (3'(w) < nw)
                    begin
                        res_w[w] = opq_q[w];
                        g_w[w]   = (c.op == tdu_pkg::OP_MV_H_G) ? hist_q[w % 2]
                                                                 : psf_q[4'(c.s_idx + 4'(w))];
                    end
                end
                if (c.op == tdu_pkg::OP_MV_G_PS)
                    psf_we = (nw == 3'h4) ? 4'hf : (nw == 3'h2) ? 4'h3 : 4'h1;
                else
                    g_we  = (nw == 3'h4) ? 4'hf : (nw == 3'h2) ? 4'h3 : 4'h1;
                if (c.op == tdu_pkg::OP_MV_H_G && nw == 3'h1)
                    g_w[0] = hist_q[c.s_idx[0]];
            end
            tdu_pkg::OP_MV_G_H:
            begin
                h_val = c.ilv ? ilv(opq_q[0], opq_q[1]) : {opq_q[1], opq_q[0]};
                if (nw == 3'h2)
                    h_we = 2'h3;
                else
                begin
                    h_val = {opq_q[0], opq_q[0]};
                    h_we  = c.s_idx[0] ? 2'h2 : 2'h1;
                end
            end
            tdu_pkg::OP_DSP_ACC:
            begin
                // samples 0..7 added to prior path-score word
                acc32 = desp(q128, hbits, 0);
                res64[31:0] = desp(q128, hbits, tdu_pkg::HALF_SAMP);
                for (int k = 0; k < 2; k++)
                begin
                    t0 = add_s(acc32[16*k +: 16], res64[16*k +: 16], 1'b0, c.sat);
                    t1 = add_s(t0[15:0], psf_q[c.n_idx][16*k +: 16], 1'b0, c.sat);
                    ovf = ovf | t0[16] | t1[16];
                    res_w[0][16*k +: 16] = t1[15:0];
                end
                psf_we  = 4'h1;
                h_shift = 1'b1;
            end
            tdu_pkg::OP_DSP_SGL:
            begin
                // samples 0..3, old value out to general
                res_w[0] = desp(q128, hbits, 0);
                g_w[0]   = psf_q[c.s_idx];
                psf_we   = 4'h1;
                g_we     = 4'h1;
                h_shift  = 1'b1;
            end
            tdu_pkg::OP_DSP_DBL:
            begin
                // low samples to first word, high to second
                res_w[0] = desp(q128, hbits, 0);
                res_w[1] = desp(q128, hbits, tdu_pkg::HALF_SAMP);
                g_w[0]   = psf_q[c.s_idx];
                g_w[1]   = psf_q[s1];
                psf_we   = 4'h3;
                g_we     = 4'h3;
                h_shift  = 1'b1;
            end
            default:
            begin
                ovf = 1'b0;
            end
        endcase
        // paired history load replaces the shift
        if (is_dsp && c.hload && c.pair == tdu_pkg::PR_COMM_LOAD)
        begin
            h_val   = c.ilv ? ilv(hld_q[0], hld_q[1]) : {hld_q[1], hld_q[0]};
            h_we    = 2'h3;
            h_shift = 1'b0;
        end
        // saturation applies through the add helpers
        if (!is_max && !is_dsp)
            ovf = 1'b0;
    end

    // ========================================
    // path-score file: bus writes or execute commits
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < tdu_pkg::PSF_DEPTH; i++)
                psf_q[i] <= '0;
        end
        // commit at end of second execute stage
        else if (go)
        begin
            for (int w = 0; w < 4; w++)
                if (psf_we[w])
                    psf_q[4'(c.s_idx + 4'(w))] <= res_w[w];
        end
        else if (wr_ack && avs_address >= tdu_pkg::A_PSF && avs_address < tdu_pkg::A_END)
            psf_q[widx] <= be_merge(psf_q[widx], avs_writedata, avs_byteenable);
    end

    // history pair
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            hist_q[0] <= '0;
            hist_q[1] <= '0;
        end
        else if (go && h_we != 2'h0)
        begin
            if (h_we[0])
                hist_q[0] <= h_val[31:0];
            if (h_we[1])
                hist_q[1] <= h_val[63:32];
        end
        else if (go && h_shift)
            {hist_q[1], hist_q[0]} <= {hist_q[1], hist_q[0]} >> tdu_pkg::HIST_SHIFT;
        else if (wr_ack && avs_address >= tdu_pkg::A_HIST && avs_address < tdu_pkg::A_HLD)
            hist_q[widx[0]] <= be_merge(hist_q[widx[0]], avs_writedata, avs_byteenable);
    end

    // operand, paired-load staging and general result words
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            for (int w = 0; w < 4; w++)
            begin
                opq_q[w]  <= '0;
                gres_q[w] <= '0;
            end
            hld_q[0] <= '0;
            hld_q[1] <= '0;
        end
        else
        begin
            if (wr_ack && avs_address >= tdu_pkg::A_OPQ && avs_address < tdu_pkg::A_GRES)
                opq_q[widx[1:0]] <= be_merge(opq_q[widx[1:0]], avs_writedata, avs_byteenable);
            if (wr_ack && avs_address >= tdu_pkg::A_HLD && avs_address < tdu_pkg::A_PSF)
                hld_q[widx[0]] <= be_merge(hld_q[widx[0]], avs_writedata, avs_byteenable);
            for (int w = 0; w < 4; w++)
                if (go && g_we[w])
                    gres_q[w] <= g_w[w];
        end
    end

    // ========================================
    // status flags
    logic stat_wr;
    assign stat_wr = wr_ack && avs_address == tdu_pkg::A_STAT;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            now_q  <= 1'b0;
            stk_q  <= 1'b0;
            perr_q <= 1'b0;
            aerr_q <= 1'b0;
        end
        else
        begin
            // live flag follows this cycle's operation only
            now_q <= go & ovf;
            // set wins over the status-write clear
            stk_q  <= (go & ovf) | (stk_q & ~stat_wr);
            perr_q <= (ex_v_q & pair_bad) | (perr_q & ~stat_wr);
            aerr_q <= (ex_v_q & align_bad) | (aerr_q & ~stat_wr);
        end
    end
endmodule : tdu_unit

// *** tdu_unit_checker.sv ***
// port assertions for the trellis despread unit
`timescale 1ns/1ps
module tdu_unit_checker (
    input wire logic        core_clk,            // clock
    input wire logic        nrst,                // reset
    input wire logic [7:0]  avs_address,         // address
    input wire logic        avs_read,            // read
    input wire logic        avs_write,           // write
    input wire logic [31:0] avs_readdata,        // data
    input wire logic        avs_waitrequest,     // stall
    input wire logic        overflow_now_flag,   // live
    input wire logic        overflow_sticky_flag // sticky
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire st_wr = avs_write && !avs_waitrequest && avs_address[7:2] == 6'h01;
    a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("idle stall");
    a_wait_bound: assert property (avs_read || avs_write |-> ##[0:4] !avs_waitrequest) else $error("no answer");
    a_now_pulse: assert property (overflow_now_flag |=> !overflow_now_flag) else $error("long pulse");
    a_now_cause: assert property ($rose(overflow_now_flag) |-> $past(avs_write && avs_address[7:2] == 6'h00, 2))
        else $error("no cause");
    a_sticky_hold: assert property (overflow_sticky_flag && !st_wr |=> overflow_sticky_flag) else $error("lost");
    a_sticky_set: assert property (overflow_now_flag |-> overflow_sticky_flag) else $error("not set");
    a_sticky_clear: assert property (st_wr |=> !overflow_sticky_flag) else $error("not clear");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("data moved");
endmodule : tdu_unit_checker
bind tdu_unit tdu_unit_checker u_chk (.*);

// *** tdu_host_model.sv ***
// bus master standing in for the decoder and register file
`timescale 1ns/1ps
module tdu_host_model (
    input  wire logic   core_clk,        // clock
    input  wire logic   avs_waitrequest, // stall
    output logic [7:0]  avs_address,     // address
    output logic        avs_read,        // read
    output logic        avs_write,       // write
    output logic [31:0] avs_writedata,   // data
    output logic [3:0]  avs_byteenable   // lanes
);
    initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = {8'h0, 2'b00, 32'h0, 4'hf};
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        {avs_read, avs_write} <= {!w, w};
        // request stands until the rising edge that samples waitrequest low
        do @(posedge core_clk); while (avs_waitrequest);
        {avs_read, avs_write} <= 2'b00;
        // one idle edge so the next call never reassigns in this time step
        @(posedge core_clk);
    endtask : xfer
endmodule : tdu_host_model

// *** tdu_unit_tb.sv ***
// self-checking bench for the trellis despread unit
`timescale 1ns/1ps
module tdu_unit_tb;
    logic        core_clk = 1'b0, nrst = 1'b0, avs_read, avs_write, avs_waitrequest;
    logic        overflow_now_flag, overflow_sticky_flag;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, exp_w, exp_q [$];
    int          failures = 0, comparisons = 0, now_pulses = 0;
    // write flag, address, data; a read carries its expected word
    logic [40:0] scr [] = '{
        41'h17000000000, 41'h07000000000, 41'h14000050003, 41'h14800010010, 41'h11800010001,
        41'h11000020002, 41'h10000024081, 41'h05000090013, 41'h05400030003, 41'h10000024082,
        41'h0500006000f, 41'h05400030003, 41'h10000024084, 41'h05000060012, 41'h10000024085,
        41'h0500004000e, 41'h14000057fff, 41'h10000024094, 41'h05000067fff, 41'h00400000002,
        41'h10400000000, 41'h10000424084, 41'h00400000004, 41'h05000067fff, 41'h10400000000,
        41'h10000040009, 41'h00400000008, 41'h1100000ffff, 41'h11800000000, 41'h10000820009,
        41'h03055555555, 41'h11001020304, 41'h1000000c10a, 41'h0600002fff6, 41'h03000005555,
        41'h08000000000, 41'h10000004003, 41'h02000077fff, 41'h1000000008b, 41'h02000067fff,
        41'h0500002fff6, 41'h1380000aaaa, 41'h1000038c10a, 41'h0300000aaaa, 41'h060000a0002,
        41'h10000020147, 41'h06801020304, 41'h10000000146, 41'h02001020304
    };
    always #5 core_clk = ~core_clk;
    tdu_unit uut (.*);
    tdu_host_model m (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        failures += int'(s !== e);
        if (s !== e) $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    endtask : check
    task complete_run(input int extra);
        failures += extra;
        // only the saturating max add overflows
        check(32'(now_pulses), 32'h1);
        // an expectation never answered is a miss too
        failures += exp_q.size();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    always @(negedge core_clk)
    begin
        now_pulses += int'(overflow_now_flag === 1'b1);
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
        begin
            exp_w = exp_q.pop_front();
            check(avs_readdata, exp_w);
            // flag pins must agree with the status word
            if (avs_address == 8'h04)
                check({30'h0, overflow_sticky_flag, overflow_now_flag}, {30'h0, exp_w[1:0]});
        end
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        scr[0][31:0] = xs(32'h1a);
        scr[1][31:0] = scr[0][31:0];
        foreach (scr[i])
        begin
            if (!scr[i][40])
                exp_q.push_back(scr[i][31:0]);
            m.xfer(scr[i][39:32], scr[i][40], scr[i][31:0]);
        end
        complete_run(0);
    end
    initial #50000 complete_run(1);
endmodule : tdu_unit_tb
